// *** src/fbi_asm_sel.sv ***
// fbi_asm_sel: decodes a selected output assembly instance into sizes and mode
// assumes the instance number is already held in a register; pure combinational
module fbi_asm_sel (
	input  wire logic [7:0]       i_out_inst, // selected output instance
	output fbi_pkg::fbi_asm_t     o_asm       // decoded layout
);

	function automatic logic [7:0] attr_len(input logic [1:0] a);
		case (a)
			2'd0:    attr_len = fbi_pkg::ATTR_LEN_1;
			2'd1:    attr_len = fbi_pkg::ATTR_LEN_2;
			2'd2:    attr_len = fbi_pkg::ATTR_LEN_3;
			default: attr_len = fbi_pkg::ATTR_LEN_4;
		endcase
	endfunction

	function automatic logic [3:0] attr_dw(input logic [1:0] a);
		case (a)
			2'd0:    attr_dw = fbi_pkg::ATTR_DW_1;
			2'd1:    attr_dw = fbi_pkg::ATTR_DW_2;
			2'd2:    attr_dw = fbi_pkg::ATTR_DW_3;
			default: attr_dw = fbi_pkg::ATTR_DW_4;
		endcase
	endfunction

	logic [7:0] rel;
	logic [1:0] attr;
	logic [7:0] slot;
	logic [7:0] size;

	always_comb begin
		rel   = i_out_inst - fbi_pkg::INST_OUT_FIRST;
		attr  = rel[1:0];
		slot  = attr_len(attr);
		o_asm = '0;
		size  = '0;
		o_asm.in_inst  = i_out_inst + fbi_pkg::INST_IN_OFFSET;
		o_asm.max_dw   = attr_dw(attr);
		if (i_out_inst == fbi_pkg::INST_HEARTBEAT) begin
			o_asm.heartbeat = 1'b1;
			o_asm.separated = 1'b1;
			o_asm.out_bytes = fbi_pkg::HB_OUT_BYTES;
			o_asm.in_bytes  = fbi_pkg::HB_IN_BYTES;
			o_asm.max_dw    = '0;
		end else if (i_out_inst >= fbi_pkg::INST_SEP_FIRST) begin
			// four equal slots, plus configuration slot from 108 upward
			o_asm.separated = 1'b1;
			o_asm.has_cfg   = (i_out_inst >= fbi_pkg::INST_CFG_FIRST);
			size = {slot[5:0], 2'b00};
			if (o_asm.has_cfg) begin
				size = size + fbi_pkg::CFG_SLOT_BYTES;
			end
			o_asm.out_bytes = size;
			o_asm.in_bytes  = size;
		end else begin
			o_asm.out_bytes = slot;
			o_asm.in_bytes  = slot;
		end
	end

endmodule // fbi_asm_sel

// *** src/fbi_front.sv ***
// fbi_front: fieldbus ident request front end, top level
// assumes requests arrive one at a time on i_req_valid, wishbone classic slave for setup
module fbi_front (
	input  wire logic               i_clk,          // 125 MHz clock
	input  wire logic               i_reset_n,      // async reset, active low
	input  wire logic               i_ce,           // clock enable, freezes state
	// wishbone classic slave
	input  wire logic               i_wb_cyc,       // cycle
	input  wire logic               i_wb_stb,       // strobe
	input  wire logic               i_wb_we,        // write enable
	input  wire logic [7:0]         i_wb_adr,       // byte address
	input  wire logic [3:0]         i_wb_sel,       // byte lanes
	input  wire logic [31:0]        i_wb_dat,       // write data
	output logic [31:0]             o_wb_dat,       // read data
	output logic                    o_wb_ack,       // acknowledge
	// modbus request / answer
	input  wire logic               i_req_valid,    // request pulse
	input  wire fbi_pkg::fbi_req_t  i_req,          // request fields
	input  wire logic               i_release,      // master closes channel
	output logic                    o_busy,         // request in flight
	output logic                    o_resp_valid,   // answer pulse
	output fbi_pkg::fbi_resp_t      o_resp,         // answer fields
	// ident responses from the channel engines
	input  wire logic               i_ident_valid,  // new ident response
	input  wire logic [1:0]         i_ident_ch,     // channel of response
	input  wire logic [7:0]         i_ident_status, // its status
	input  wire logic [7:0]         i_ident_len,    // its telegram length
	input  wire logic               i_read_ch,      // channel read pulse
	input  wire logic [1:0]         i_read_ch_sel,  // channel being read
	output logic                    o_new_data,     // fresh response on read
	output logic [7:0]              o_reply_cnt,    // counter of read channel
	output logic [79:0]             o_hb_field,     // heartbeat input field
	// ethernet/ip selection
	input  wire logic               i_fwd_open,     // forward open pulse
	input  wire logic [7:0]         i_fwd_inst,     // instance from forward open
	output logic [7:0]              o_out_inst,     // active output instance
	output fbi_pkg::fbi_asm_t       o_asm           // decoded layout
);

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0]  out_inst;
	logic [7:0]  next_out_inst;
	logic        enip_en;
	logic        next_enip_en;
	logic        wb_ack;
	logic        next_wb_ack;
	logic [31:0] wb_dat;
	logic [31:0] next_wb_dat;
	logic        bad_inst;
	logic        next_bad_inst;

	fbi_pkg::fbi_state_t state;
	fbi_pkg::fbi_state_t next_state;
	fbi_pkg::fbi_req_t   req;
	fbi_pkg::fbi_req_t   next_req;
	fbi_pkg::fbi_resp_t  resp;
	fbi_pkg::fbi_resp_t  next_resp;
	fbi_pkg::fbi_resp_t  chk;
	logic                resp_v;
	logic                next_resp_v;
	logic [23:0]         owner;
	logic [23:0]         next_owner;

	logic [7:0]  cnt   [3];
	logic [7:0]  stat  [3];
	logic [7:0]  len   [3];
	logic [2:0]  pend;
	logic [7:0]  next_cnt  [3];
	logic [7:0]  next_stat [3];
	logic [7:0]  next_len  [3];
	logic [2:0]  next_pend;
	logic        new_data;
	logic        next_new_data;
	logic [7:0]  rcnt;
	logic [7:0]  next_rcnt;

	function automatic logic inst_ok(input logic [7:0] n);
		inst_ok = (n >= fbi_pkg::INST_OUT_FIRST) && (n <= fbi_pkg::INST_OUT_LAST);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		for (int b = 0; b < 4; b++) begin
			merge[8*b +: 8] = sel[b] ? d[8*b +: 8] : old[8*b +: 8];
		end
	endfunction

	fbi_asm_sel u_asm (
		.i_out_inst (out_inst),
		.o_asm      (o_asm)
	);

	fbi_mb_check u_chk (
		.i_req   (req),
		.i_owner (owner),
		.o_resp  (chk)
	);

	////////////////////////////////////////////////////////////////////////
	// wishbone slave and assembly selection

	logic [31:0] ctrl_word;
	logic [31:0] wr_word;

	always_comb begin
		next_out_inst = out_inst;
		next_enip_en  = enip_en;
		next_bad_inst = bad_inst;
		next_wb_ack   = 1'b0;
		next_wb_dat   = wb_dat;
		ctrl_word     = {23'h0, enip_en, out_inst};
		wr_word       = merge(ctrl_word, i_wb_dat, i_wb_sel);
		// forward open selects the pair too; bad numbers are refused
		if (i_fwd_open) begin
			if (inst_ok(i_fwd_inst)) begin
				next_out_inst = i_fwd_inst;
				next_bad_inst = 1'b0;
			end else begin
				next_bad_inst = 1'b1;
			end
		end
		if (i_wb_cyc && i_wb_stb && !wb_ack) begin
			next_wb_ack = 1'b1;
			next_wb_dat = 32'h0;
			case (i_wb_adr)
				fbi_pkg::REG_CTRL: begin
					next_wb_dat = ctrl_word;
					if (i_wb_we) begin
						// enip framing has no length field, so none is kept
						next_enip_en = wr_word[fbi_pkg::CTRL_ENIP_BIT];
						// attribute 100 of instance 0 equivalent
						if (inst_ok(wr_word[7:0])) begin
							next_out_inst = wr_word[7:0];
							next_bad_inst = 1'b0;
						end else begin
							next_bad_inst = 1'b1;
						end
					end
				end
				fbi_pkg::REG_STATUS: next_wb_dat = {6'h0, bad_inst, o_busy, owner};
				fbi_pkg::REG_ASM:    next_wb_dat = {o_asm.max_dw, o_asm.separated, o_asm.heartbeat,
					o_asm.has_cfg, 1'b0, o_asm.in_inst, o_asm.out_bytes, o_asm.in_bytes};
				fbi_pkg::REG_HB0:    next_wb_dat = {16'h0, o_hb_field[15:0]};
				fbi_pkg::REG_HB1:    next_wb_dat = {16'h0, o_hb_field[31:16]};
				fbi_pkg::REG_HB2:    next_wb_dat = {16'h0, o_hb_field[47:32]};
				default:             next_wb_dat = 32'h0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			out_inst <= fbi_pkg::INST_RESET;
			enip_en  <= fbi_pkg::CTRL_RESET[fbi_pkg::CTRL_ENIP_BIT];
			bad_inst <= 1'b0;
			wb_ack   <= 1'b0;
			wb_dat   <= 32'h0;
		end else if (i_ce) begin
			out_inst <= next_out_inst;
			enip_en  <= next_enip_en;
			bad_inst <= next_bad_inst;
			wb_ack   <= next_wb_ack;
			wb_dat   <= next_wb_dat;
		end
	end

	assign o_wb_ack   = wb_ack;
	assign o_wb_dat   = wb_dat;
	assign o_out_inst = out_inst;

	////////////////////////////////////////////////////////////////////////
	// modbus request sequencer

	always_comb begin
		next_state  = state;
		next_req    = req;
		next_resp   = resp;
		next_resp_v = 1'b0;
		next_owner  = owner;
		// a release names the master; all its channels become free
		if (i_release) begin
			for (int c = 0; c < 3; c++) begin
				if (owner[8*c +: 8] == i_req.master_id) begin
					next_owner[8*c +: 8] = fbi_pkg::MASTER_NONE;
				end
			end
		end
		case (state)
			fbi_pkg::FBI_IDLE: begin
				if (i_req_valid) begin
					next_req   = i_req;
					next_state = fbi_pkg::FBI_CHECK;
				end
			end
			fbi_pkg::FBI_CHECK: begin
				next_resp  = chk;
				if (!chk.exc) begin
					next_owner[8*chk.channel +: 8] = req.master_id;
				end
				next_state = fbi_pkg::FBI_ANSW;
			end
			fbi_pkg::FBI_ANSW: begin
				next_resp_v = 1'b1;
				next_state  = fbi_pkg::FBI_IDLE;
			end
			default: next_state = fbi_pkg::FBI_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state  <= fbi_pkg::FBI_IDLE;
			req    <= '0;
			resp   <= '0;
			resp_v <= 1'b0;
			owner  <= {3{fbi_pkg::MASTER_NONE}};
		end else if (i_ce) begin
			state  <= next_state;
			req    <= next_req;
			resp   <= next_resp;
			resp_v <= next_resp_v;
			owner  <= next_owner;
		end
	end

	assign o_busy       = (state != fbi_pkg::FBI_IDLE);
	assign o_resp_valid = resp_v;
	assign o_resp       = resp;

	////////////////////////////////////////////////////////////////////////
	// reply counters and once-only delivery

	always_comb begin
		next_pend     = pend;
		next_new_data = 1'b0;
		next_rcnt     = rcnt;
		for (int c = 0; c < 3; c++) begin
			next_cnt[c]  = cnt[c];
			next_stat[c] = stat[c];
			next_len[c]  = len[c];
		end
		// read consumes the pending flag first, so a same-cycle arrival survives
		if (i_read_ch && i_read_ch_sel < 2'd3) begin
			next_rcnt     = cnt[i_read_ch_sel];
			next_new_data = pend[i_read_ch_sel] && len[i_read_ch_sel] != 8'h00
				&& stat[i_read_ch_sel] == 8'h00;
			next_pend[i_read_ch_sel] = 1'b0;
		end
		if (i_ident_valid && i_ident_ch < 2'd3) begin
			next_cnt[i_ident_ch]  = cnt[i_ident_ch] + 8'h01;
			next_stat[i_ident_ch] = i_ident_status;
			next_len[i_ident_ch]  = i_ident_len;
			next_pend[i_ident_ch] = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int c = 0; c < 3; c++) begin
				cnt[c]  <= 8'h00;
				stat[c] <= 8'h00;
				len[c]  <= 8'h00;
			end
			pend     <= 3'h0;
			new_data <= 1'b0;
			rcnt     <= 8'h00;
		end else if (i_ce) begin
			for (int c = 0; c < 3; c++) begin
				cnt[c]  <= next_cnt[c];
				stat[c] <= next_stat[c];
				len[c]  <= next_len[c];
			end
			pend     <= next_pend;
			new_data <= next_new_data;
			rcnt     <= next_rcnt;
		end
	end

	assign o_new_data  = new_data;
	assign o_reply_cnt = rcnt;
	// byte 0 first: unit, channel 1, channel 2; bytes 6..9 reserved zero
	assign o_hb_field  = {32'h0, cnt[2], stat[2], cnt[1], stat[1], cnt[0], stat[0]};

endmodule // fbi_front

// *** src/fbi_mb_check.sv ***
// fbi_mb_check: classifies one modbus request into normal or exception answer
// assumes owner table of channels is supplied by the caller
module fbi_mb_check (
	input  wire fbi_pkg::fbi_req_t  i_req,    // request fields
	input  wire logic [23:0]        i_owner,  // owner master per channel
	output fbi_pkg::fbi_resp_t      o_resp    // classified answer
);

	logic [1:0]  ch;
	logic [16:0] last;
	logic [7:0]  own;

	always_comb begin
		// channel comes from the address, the telegram's channel is ignored
		if (i_req.addr >= fbi_pkg::CH2_BASE) begin
			ch = 2'd2;
		end else if (i_req.addr >= fbi_pkg::CH1_BASE) begin
			ch = 2'd1;
		end else begin
			ch = 2'd0;
		end
		own  = i_owner[8*ch +: 8];
		// one spare bit so a start near the top cannot wrap past the range check
		last = {1'b0, i_req.addr} + {9'h000, i_req.count};
		o_resp.exc     = 1'b1;
		o_resp.func    = i_req.func | fbi_pkg::FC_EXC_FLAG;
		o_resp.channel = ch;
		// checks in modbus priority order
		if (i_req.unit_id != fbi_pkg::UNIT_ID_A && i_req.unit_id != fbi_pkg::UNIT_ID_B) begin
			o_resp.code = fbi_pkg::EX_GATEWAY;
		end else if (i_req.func != fbi_pkg::FC_READ_HOLD && i_req.func != fbi_pkg::FC_WRITE_MULTI
			&& i_req.func != fbi_pkg::FC_READ_WRITE) begin
			o_resp.code = fbi_pkg::EX_ILL_FUNC;
		end else if (i_req.count == 8'h00 || (i_req.func == fbi_pkg::FC_WRITE_MULTI
			&& i_req.count > fbi_pkg::MAX_WR_REGS) || i_req.count > fbi_pkg::MAX_RD_REGS) begin
			o_resp.code = fbi_pkg::EX_ILL_VALUE;
		end else if (last > {1'b0, fbi_pkg::ADDR_END}) begin
			o_resp.code = fbi_pkg::EX_ILL_ADDR;
		end else if (own != fbi_pkg::MASTER_NONE && own != i_req.master_id) begin
			o_resp.code = fbi_pkg::EX_BUSY;
		end else begin
			o_resp.exc  = 1'b0;
			o_resp.func = i_req.func;
			o_resp.code = 8'h00;
		end
	end

endmodule // fbi_mb_check

// *** src/fbi_pkg.sv ***
// fbi_pkg: constants, types and register map of the fieldbus ident request front end
// assumes one 125 MHz clock domain; shared by all design files of the block
package fbi_pkg;

	// modbus function and exception codes
	localparam logic [7:0] FC_READ_HOLD   = 8'h03;
	localparam logic [7:0] FC_WRITE_MULTI = 8'h16;
	localparam logic [7:0] FC_READ_WRITE  = 8'h17;
	localparam logic [7:0] FC_EXC_FLAG    = 8'h80;
	localparam logic [7:0] EX_ILL_FUNC    = 8'h01;
	localparam logic [7:0] EX_ILL_ADDR    = 8'h02;
	localparam logic [7:0] EX_ILL_VALUE   = 8'h03;
	localparam logic [7:0] EX_BUSY        = 8'h06;
	localparam logic [7:0] EX_GATEWAY     = 8'h0a;
	localparam logic [7:0] UNIT_ID_A      = 8'h01;
	localparam logic [7:0] UNIT_ID_B      = 8'h02;

	// channel register windows
	localparam logic [15:0] CH0_BASE      = 16'h0000;
	localparam logic [15:0] CH1_BASE      = 16'h03e8;
	localparam logic [15:0] CH2_BASE      = 16'h07d0;
	localparam logic [15:0] CH_SPAN       = 16'h03e8;
	localparam logic [15:0] ADDR_END      = 16'h0bb8;
	localparam logic [7:0]  MAX_WR_REGS   = 8'h79;
	localparam logic [7:0]  MAX_RD_REGS   = 8'h7d;
	localparam logic [7:0]  MASTER_NONE   = 8'hff;

	// assembly instances
	localparam logic [7:0] INST_OUT_FIRST = 8'h64;
	localparam logic [7:0] INST_OUT_LAST  = 8'h70;
	localparam logic [7:0] INST_IN_OFFSET = 8'h32;
	localparam logic [7:0] INST_SEP_FIRST = 8'h68;
	localparam logic [7:0] INST_CFG_FIRST = 8'h6c;
	localparam logic [7:0] INST_HEARTBEAT = 8'h70;
	localparam logic [7:0] CFG_SLOT_BYTES = 8'h08;
	localparam logic [7:0] HB_OUT_BYTES   = 8'h00;
	localparam logic [7:0] HB_IN_BYTES    = 8'h0a;
	localparam logic [7:0] INST_RESET     = 8'h64;

	// attribute data lengths and double word limits, attributes 1..4
	localparam logic [7:0] ATTR_LEN_1 = 8'h08;
	localparam logic [7:0] ATTR_LEN_2 = 8'h0c;
	localparam logic [7:0] ATTR_LEN_3 = 8'h20;
	localparam logic [7:0] ATTR_LEN_4 = 8'h3c;
	localparam logic [3:0] ATTR_DW_1  = 4'h1;
	localparam logic [3:0] ATTR_DW_2  = 4'h2;
	localparam logic [3:0] ATTR_DW_3  = 4'h7;
	localparam logic [3:0] ATTR_DW_4  = 4'he;

	// wishbone register map (byte addresses)
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [7:0]  REG_ASM      = 8'h08;
	localparam logic [7:0]  REG_HB0      = 8'h0c;
	localparam logic [7:0]  REG_HB1      = 8'h10;
	localparam logic [7:0]  REG_HB2      = 8'h14;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0064;
	localparam int          CTRL_INST_LO = 0;
	localparam int          CTRL_ENIP_BIT = 8;

	typedef struct packed {
		logic [7:0]  master_id;
		logic [7:0]  unit_id;
		logic [7:0]  func;
		logic [15:0] addr;
		logic [7:0]  count;
	} fbi_req_t;

	typedef struct packed {
		logic       exc;
		logic [7:0] func;
		logic [7:0] code;
		logic [1:0] channel;
	} fbi_resp_t;

	typedef struct packed {
		logic       separated;
		logic       heartbeat;
		logic       has_cfg;
		logic [7:0] in_inst;
		logic [7:0] out_bytes;
		logic [7:0] in_bytes;
		logic [3:0] max_dw;
	} fbi_asm_t;

	typedef enum logic [1:0] {
		FBI_IDLE  = 2'b00,
		FBI_CHECK = 2'b01,
		FBI_ANSW  = 2'b10
	} fbi_state_t;

endpackage : fbi_pkg

// *** tb/fbi_front_sva.sv ***
// fbi_front_sva: port assertions for fbi_front
// assumes one clock domain, async active-low reset; bound at the foot
module fbi_front_sva (
	input wire logic               i_clk,        // clock
	input wire logic               i_reset_n,    // reset, active low
	input wire logic               i_wb_cyc,     // cycle
	input wire logic               i_wb_stb,     // strobe
	input wire logic               o_wb_ack,     // acknowledge
	input wire logic               i_req_valid,  // request pulse
	input wire fbi_pkg::fbi_req_t  i_req,        // request fields
	input wire logic               o_busy,       // request in flight
	input wire logic               o_resp_valid, // answer pulse
	input wire fbi_pkg::fbi_resp_t o_resp,       // answer fields
	input wire logic               i_read_ch,    // channel read pulse
	input wire logic               o_new_data,   // fresh response
	input wire logic [7:0]         o_out_inst,   // output instance
	input wire fbi_pkg::fbi_asm_t  o_asm         // decoded layout
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	logic       unit_ok;
	logic       func_ok;
	logic [1:0] chan;
	assign unit_ok = (i_req.unit_id == fbi_pkg::UNIT_ID_A) || (i_req.unit_id == fbi_pkg::UNIT_ID_B);
	assign func_ok = (i_req.func == fbi_pkg::FC_READ_HOLD) || (i_req.func == fbi_pkg::FC_WRITE_MULTI)
		|| (i_req.func == fbi_pkg::FC_READ_WRITE);
	assign chan = (i_req.addr >= fbi_pkg::CH2_BASE) ? 2'h2 : (i_req.addr >= fbi_pkg::CH1_BASE) ? 2'h1 : 2'h0;
	////////////////////////////////////////////////////////////////////////////////
	wb_ack_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("wb ack late");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("wb ack held");
	resp_time_a: assert property (i_req_valid && !o_busy |=> o_busy ##[1:2] o_resp_valid)
		else $error("answer missing");
	one_resp_a: assert property (o_resp_valid |=> !o_resp_valid [*2]) else $error("answer repeated");
	unit_exc_a: assert property (o_resp_valid && !unit_ok |-> o_resp.exc && o_resp.code == fbi_pkg::EX_GATEWAY)
		else $error("unit id not refused");
	func_exc_a: assert property (o_resp_valid && unit_ok && !func_ok |-> o_resp.exc
		&& o_resp.code == fbi_pkg::EX_ILL_FUNC) else $error("function not refused");
	count_exc_a: assert property (o_resp_valid && unit_ok && func_ok && i_req.count == 8'h00
		|-> o_resp.exc && o_resp.code == fbi_pkg::EX_ILL_VALUE) else $error("zero count not refused");
	exc_echo_a: assert property (o_resp_valid && o_resp.exc |-> o_resp.func == (i_req.func | fbi_pkg::FC_EXC_FLAG))
		else $error("exception function wrong");
	chan_route_a: assert property (o_resp_valid && !o_resp.exc |-> o_resp.channel == chan)
		else $error("channel not from address");
	new_once_a: assert property (o_new_data |-> $past(i_read_ch)) else $error("new data without read");
	inst_pair_a: assert property (o_asm.in_inst == o_out_inst + fbi_pkg::INST_IN_OFFSET) else $error("pair offset");
	mixed_mode_a: assert property (o_out_inst < fbi_pkg::INST_SEP_FIRST |-> !o_asm.separated)
		else $error("mixed shown separated");
	sep_mode_a: assert property (o_out_inst >= fbi_pkg::INST_SEP_FIRST && o_out_inst < fbi_pkg::INST_HEARTBEAT
		|-> o_asm.separated && !o_asm.heartbeat) else $error("separated mode wrong");
	hb_size_a: assert property (o_out_inst == fbi_pkg::INST_HEARTBEAT |-> o_asm.heartbeat
		&& o_asm.out_bytes == 8'h00 && o_asm.in_bytes == 8'h0a) else $error("heartbeat sizes");
	cover property (o_resp_valid && o_resp.exc);
	cover property (o_resp_valid && !o_resp.exc);
	cover property (o_new_data);
	cover property (o_asm.heartbeat);
endmodule // fbi_front_sva

bind fbi_front fbi_front_sva chk_u (.i_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_req_valid, .i_req,
	.o_busy, .o_resp_valid, .o_resp, .i_read_ch, .o_new_data, .o_out_inst, .o_asm);

// *** tb/fbi_mb_master.sv ***
// fbi_mb_master: behavioural modbus master facing fbi_front
// assumes its tasks are entered just after a rising edge of i_clk
module fbi_mb_master (
	input  wire logic               i_clk,        // clock
	input  wire logic               i_busy,       // device busy
	input  wire logic               i_resp_valid, // answer pulse
	input  wire fbi_pkg::fbi_resp_t i_resp,       // answer fields
	output logic                    o_req_valid,  // request pulse
	output fbi_pkg::fbi_req_t       o_req,        // request fields, held until answered
	output logic                    o_release     // close owned channels
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_req_valid = 1'b0;
		o_req = '0;
		o_release = 1'b0;
	end
	// one session for every transaction, torn down in between only by close
	task automatic send(input fbi_pkg::fbi_req_t r, output fbi_pkg::fbi_resp_t a, output logic ok);
		int n;
		ok = 1'b0;
		a = '0;
		for (n = 0; n < 8 && i_busy !== 1'b0; n++) @(posedge i_clk);
		o_req <= r;
		o_req_valid <= 1'b1;
		@(posedge i_clk);
		o_req_valid <= 1'b0;
		// short bound stands in for the transaction timeout
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge i_clk);
			if (i_resp_valid === 1'b1) begin
				a = i_resp;
				ok = 1'b1;
			end
		end
	endtask
	task automatic close(input logic [7:0] m);
		o_req.master_id <= m;
		o_release <= 1'b1;
		@(posedge i_clk);
		o_release <= 1'b0;
	endtask
	// polled after every arrival, so no answer is overtaken
	function automatic logic is_new(input logic [7:0] len, cnt, prev, st);
		return len != 8'h00 && cnt != prev && st == 8'h00;
	endfunction
endmodule // fbi_mb_master

// *** tb/tb_top.sv ***
// tb_top: self-checking bench for fbi_front
// assumes fbi_mb_master as the far-side master, checker bound to the design
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic               i_clk = 1'b0, i_reset_n = 1'b0, i_ce = 1'b1;
	logic               i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	logic [7:0]         i_wb_adr = '0;
	logic [3:0]         i_wb_sel = '0;
	logic [31:0]        i_wb_dat = '0, o_wb_dat, q;
	logic               o_wb_ack, i_req_valid, i_release, o_busy, o_resp_valid, o_new_data, ok, nd;
	fbi_pkg::fbi_req_t  i_req, r;
	fbi_pkg::fbi_resp_t o_resp, a, e;
	logic               i_ident_valid = 1'b0, i_read_ch = 1'b0, i_fwd_open = 1'b0;
	logic [1:0]         i_ident_ch = '0, i_read_ch_sel = '0;
	logic [7:0]         i_ident_status = '0, i_ident_len = '0, i_fwd_inst = '0, o_reply_cnt, o_out_inst, eb;
	logic [79:0]        o_hb_field;
	fbi_pkg::fbi_asm_t  o_asm;
	logic [7:0]         own [3] = '{8'hff, 8'hff, 8'hff};
	logic [7:0]         ecnt [3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0]         prev [3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0]         slot [4] = '{8'h08, 8'h0c, 8'h20, 8'h3c};
	logic [3:0]         dws [4] = '{4'h1, 4'h2, 4'h7, 4'he};
	logic [31:0]        idt [5] = '{32'h01010006, 32'h00010006, 32'h01010506, 32'h01010000, 32'h01020004};
	fbi_pkg::fbi_req_t  corner [8] = '{'{8'h01, 8'h01, 8'h16, 16'h0000, 8'h79}, '{8'h01, 8'h01, 8'h16, 16'h0000, 8'h7a},
		'{8'h02, 8'h02, 8'h03, 16'h0000, 8'h01}, '{8'h02, 8'h01, 8'h17, 16'h0bae, 8'h0a},
		'{8'h02, 8'h01, 8'h03, 16'h0bae, 8'h0b}, '{8'h01, 8'h00, 8'h03, 16'h0000, 8'h01},
		'{8'h01, 8'h01, 8'h05, 16'h0000, 8'h01}, '{8'h01, 8'h01, 8'h03, 16'h03e7, 8'h00}};
	integer             seed = 32'hd081;
	int                 n_mismatch = 0, num_checks = 0, i, k, inst;

	always #4 i_clk = ~i_clk;

	fbi_front dut_u (.i_clk, .i_reset_n, .i_ce, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
		.o_wb_dat, .o_wb_ack, .i_req_valid, .i_req, .i_release, .o_busy, .o_resp_valid, .o_resp, .i_ident_valid,
		.i_ident_ch, .i_ident_status, .i_ident_len, .i_read_ch, .i_read_ch_sel, .o_new_data, .o_reply_cnt,
		.o_hb_field, .i_fwd_open, .i_fwd_inst, .o_out_inst, .o_asm);
	fbi_mb_master mst_u (.i_clk, .i_busy(o_busy), .i_resp_valid(o_resp_valid), .i_resp(o_resp),
		.o_req_valid(i_req_valid), .o_req(i_req), .o_release(i_release));

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] rd);
		int n;
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= adr;
		i_wb_dat <= d;
		i_wb_sel <= 4'hf;
		for (n = 0; n < 16; n++) begin
			@(posedge i_clk);
			if (o_wb_ack === 1'b1) break;
		end
		if (n == 16) begin
			n_mismatch++;
			conclude();
		end
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we <= 1'b0;
		@(posedge i_clk);
	endtask

	// owner table kept beside the device's own, in priority order of the checks
	function automatic fbi_pkg::fbi_resp_t exp_mb(input fbi_pkg::fbi_req_t x);
		fbi_pkg::fbi_resp_t y;
		logic [1:0]         c;
		y = '0;
		y.exc = 1'b1;
		y.func = x.func | fbi_pkg::FC_EXC_FLAG;
		c = (x.addr >= 16'h07d0) ? 2'h2 : (x.addr >= 16'h03e8) ? 2'h1 : 2'h0;
		if (x.unit_id != 8'h01 && x.unit_id != 8'h02) y.code = 8'h0a;
		else if (x.func != 8'h03 && x.func != 8'h16 && x.func != 8'h17) y.code = 8'h01;
		else if (x.count == 8'h00 || x.count > ((x.func == 8'h16) ? 8'h79 : 8'h7d)) y.code = 8'h03;
		else if (int'(x.addr) + int'(x.count) > 3000) y.code = 8'h02;
		else if (own[c] != 8'hff && own[c] != x.master_id) y.code = 8'h06;
		else begin
			y.exc = 1'b0;
			y.func = x.func;
			y.channel = c;
			own[c] = x.master_id;
		end
		return y;
	endfunction

	initial begin
		repeat (6) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		wb(1'b0, fbi_pkg::REG_CTRL, 32'h0, q);
		`CHK(q, fbi_pkg::CTRL_RESET)
		wb(1'b0, 8'hfc, 32'h0, q);
		`CHK(q, 32'h0)
		for (inst = 100; inst <= 112; inst++) begin
			k = (inst - 100) % 4;
			eb = (inst == 112) ? 8'h0a : (inst < 104) ? slot[k] : 8'(slot[k] * 4 + ((inst >= 108) ? 8 : 0));
			wb(1'b1, fbi_pkg::REG_CTRL, 32'(inst), q);
			`CHK(o_out_inst, 8'(inst))
			`CHK(o_asm.in_inst, 8'(inst + 50))
			`CHK(o_asm.in_bytes, eb)
			`CHK(o_asm.out_bytes, (inst == 112) ? 8'h00 : eb)
			`CHK(o_asm.has_cfg, 1'(inst >= 108 && inst <= 111))
			if (inst < 112) begin
				`CHK(o_asm.separated, 1'(inst >= 104))
				`CHK(o_asm.max_dw, dws[k])
			end
		end
		wb(1'b1, fbi_pkg::REG_CTRL, 32'h71, q);
		`CHK(o_out_inst, 8'h70)
		wb(1'b0, fbi_pkg::REG_STATUS, 32'h0, q);
		`CHK(q[25], 1'b1)
		i_ce <= 1'b0;
		i_fwd_open <= 1'b1;
		i_fwd_inst <= 8'h69;
		repeat (2) @(posedge i_clk);
		`CHK(o_out_inst, 8'h70)
		i_ce <= 1'b1;
		@(posedge i_clk);
		i_fwd_open <= 1'b0;
		@(posedge i_clk);
		`CHK(o_out_inst, 8'h69)
		wb(1'b0, fbi_pkg::REG_ASM, 32'h0, q);
		`CHK(q, 32'h289b_3030)
		for (i = 0; i < 60; i++) begin
			if (i < 8) r = corner[i];
			else begin
				k = {$random(seed)} % 8;
				r.master_id = 8'(1 + {$random(seed)} % 2);
				r.unit_id = (k < 6) ? 8'(1 + k % 2) : 8'(k * 3);
				k = {$random(seed)} % 5;
				r.func = (k == 0) ? 8'h03 : (k == 1) ? 8'h16 : (k == 2) ? 8'h17 : 8'($random(seed));
				r.addr = 16'({$random(seed)} % 3100);
				r.count = 8'({$random(seed)} % 130);
			end
			if (i % 12 == 8) begin
				mst_u.close(r.master_id);
				for (k = 0; k < 3; k++) if (own[k] == r.master_id) own[k] = 8'hff;
			end
			e = exp_mb(r);
			mst_u.send(r, a, ok);
			if (ok !== 1'b1) begin
				n_mismatch++;
				conclude();
			end
			`CHK(a.exc, e.exc)
			`CHK(a.func, e.func)
			if (e.exc) `CHK(a.code, e.code)
			else `CHK(a.channel, e.channel)
		end
		for (i = 0; i < 5; i++) begin
			k = int'(idt[i][17:16]);
			if (idt[i][24]) begin
				i_ident_valid <= 1'b1;
				i_ident_ch <= idt[i][17:16];
				i_ident_status <= idt[i][15:8];
				i_ident_len <= idt[i][7:0];
				@(posedge i_clk);
				i_ident_valid <= 1'b0;
				ecnt[k] = ecnt[k] + 8'h01;
			end
			i_read_ch <= 1'b1;
			i_read_ch_sel <= idt[i][17:16];
			@(posedge i_clk);
			i_read_ch <= 1'b0;
			@(posedge i_clk);
			`CHK(o_reply_cnt, ecnt[k])
			`CHK(o_new_data, mst_u.is_new(idt[i][7:0], ecnt[k], prev[k], idt[i][15:8]))
			prev[k] = ecnt[k];
		end
		`CHK(o_hb_field, {32'h0, 8'h01, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00})
		wb(1'b0, fbi_pkg::REG_HB1, 32'h0, q);
		`CHK(q, 32'h0000_0300)
		conclude();
	end
endmodule // tb_top
